// ---- rtl/dsleep_gate_consts.svh ----
// Purpose: offsets, field positions, reset values of the gating block
// Assumes: 32-bit word registers on an AHB-Lite slave
// Notes: include once; definitions only
`ifndef DSLEEP_GATE_CONSTS_SVH
`define DSLEEP_GATE_CONSTS_SVH

`define SYSCTL_BASE 32'h400F_E000
`define RUN_CLOCK_CONFIG_OFF 12'h060
`define RUN_CLOCK_GATE_1_OFF 12'h104
`define SLEEP_CLOCK_GATE_1_OFF 12'h114
`define DEEP_SLEEP_CLOCK_GATE_1_OFF 12'h124
`define POWER_MODE_OFF 12'h200
`define IRQ_STATUS_OFF 12'h204
`define IRQ_MASK_OFF 12'h208
`define GATE_WRITABLE_MASK 32'h0307_1013
`define GATE_RESET 32'h0000_0000
`define RUN_CLOCK_CONFIG_RESET 32'h0000_0000
`define AUTO_CLOCK_GATING_SELECT_BIT 27
`define COMPARATOR_UNIT1_BIT 25
`define COMPARATOR_UNIT0_BIT 24
`define TIMER_UNIT2_BIT 18
`define TIMER_UNIT1_BIT 17
`define TIMER_UNIT0_BIT 16
`define TWO_WIRE_UNIT0_BIT 12
`define SYNC_SERIAL_UNIT0_BIT 4
`define ASYNC_SERIAL_UNIT1_BIT 1
`define ASYNC_SERIAL_UNIT0_BIT 0
`define IRQ_FAULT_BIT 0
`define IRQ_MODE_BIT 1
`define IRQ_WIDTH 2
`define SYNC_STAGES 2

`endif

// ---- rtl/dsleep_gate_pkg.sv ----
// Purpose: types shared by the gating block
// Assumes: nothing
// Notes: numbers live in the constants header
package dsleep_gate_pkg;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP_SLEEP = 2'b10
  } power_mode_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ERR1 = 2'b01,
    BUS_ERR2 = 2'b10
  } bus_state_type;
endpackage

// ---- rtl/clock_gate_cell.sv ----
// Purpose: glitch-free clock gate for one unit
// Assumes: enable changes only from hclk-domain flops
// Notes: enable latched while clock is low
`timescale 1ns/100ps
`default_nettype none
module clock_gate_cell (
  input wire logic clk_in,
  input wire logic enable,
  output logic clk_out
);
  logic enable_latch;

  // Transparent while low so the pulse is never cut short
  always_latch begin
    if (!clk_in) begin
      enable_latch = enable;
    end
  end

  assign clk_out = clk_in & enable_latch;
endmodule // clock_gate_cell
`default_nettype wire

// ---- rtl/level_sync.sv ----
// Purpose: two-flop synchroniser for a level
// Assumes: asynchronous source
// Notes: first stage read only by the second
`timescale 1ns/100ps
`default_nettype none
module level_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule // level_sync
`default_nettype wire

// ---- rtl/deep_sleep_peripheral_clock_gate.sv ----
// Purpose: run/sleep/deep-sleep clock gating for one peripheral group
// Assumes: AHB-Lite slave, single word transfers, hclk 125 MHz
// Notes: fault check on peripheral accesses via unit_sel/unit_access
//
// How it works
// - A set gating bit clocks its unit; clear leaves it unclocked.
// - Access to an unclocked unit gets a bus fault.
// - Deep-sleep gating register resets to all zeros.
// - Run, sleep, deep-sleep register applied by current power mode.
// - Sleep registers used only when auto gating select bit is set.
// - Bits 18,17,16 gate timers 2,1,0.
// - Bit 12 gates the two-wire serial unit.
// - Bit 4 gates the synchronous serial unit.
// - Bits 1,0 gate asynchronous serial units 1,0.
// - Reserved gating-register bits read zero and ignore writes; run clock config keeps all 32 bits.
// - Deep-sleep register decoded at offset 0x124.
`timescale 1ns/100ps
`default_nettype none
`include "dsleep_gate_consts.svh"
module deep_sleep_peripheral_clock_gate
  import dsleep_gate_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic [9:0] unit_sel,
  input wire logic unit_access,
  output logic unit_fault,
  output logic comparator_unit1_gate,
  output logic comparator_unit0_gate,
  output logic timer_unit2_gate,
  output logic timer_unit1_gate,
  output logic timer_unit0_gate,
  output logic two_wire_unit0_gate,
  output logic sync_serial_unit0_gate,
  output logic async_serial_unit1_gate,
  output logic async_serial_unit0_gate,
  output logic [8:0] unit_clk,
  output logic irq
);
  logic [31:0] run_clock_gate_1_reg;
  logic [31:0] sleep_clock_gate_1_reg;
  logic [31:0] deep_sleep_clock_gate_1_reg;
  logic [31:0] run_clock_config_reg;
  logic [`IRQ_WIDTH-1:0] irq_status_reg;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg;
  logic [31:0] gate_reg;
  logic [31:0] gate_next;
  power_mode_type mode_reg;
  power_mode_type mode_next;
  bus_state_type bus_state_reg;
  logic sleep_sync;
  logic deep_sleep_sync;
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [11:0] dp_addr_reg;
  logic addr_ok;
  logic offset_mapped;
  logic wr_en;
  logic fault_evt;
  logic mode_evt;
  logic [31:0] wdata_gate;
  logic [8:0] gate_bits;
  logic [9:0] unit_enabled;

  // Mode requests arrive from outside this clock's timing
  level_sync u_sleep_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(sleep_req),
    .sync_out(sleep_sync)
  );

  level_sync u_deep_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(deep_sleep_req),
    .sync_out(deep_sleep_sync)
  );

  // Only mapped word offsets of this block are taken; anything else is
  // tagged in the data phase so that it answers ERROR and writes nothing
  always_comb begin
    case (haddr[11:0])
      `RUN_CLOCK_CONFIG_OFF,
      `RUN_CLOCK_GATE_1_OFF,
      `SLEEP_CLOCK_GATE_1_OFF,
      `DEEP_SLEEP_CLOCK_GATE_1_OFF,
      `POWER_MODE_OFF,
      `IRQ_STATUS_OFF,
      `IRQ_MASK_OFF: begin
        offset_mapped = 1'b1;
      end
      default: begin
        offset_mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    addr_ok = (haddr[31:12] == 20'(`SYSCTL_BASE >> 12))
      && (haddr[1:0] == 2'b00) && (hsize == 3'b010) && offset_mapped;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 12'h000;
    end else if (hready) begin
      dp_valid_reg <= hsel && htrans[1];
      dp_write_reg <= hwrite;
      dp_addr_reg <= addr_ok ? haddr[11:0] : 12'hFFF;
    end
  end

  assign wr_en = dp_valid_reg && dp_write_reg && (bus_state_reg == BUS_IDLE);
  assign wdata_gate = hwdata & `GATE_WRITABLE_MASK;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_clock_gate_1_reg <= `GATE_RESET;
      sleep_clock_gate_1_reg <= `GATE_RESET;
      deep_sleep_clock_gate_1_reg <= `GATE_RESET;
      run_clock_config_reg <= `RUN_CLOCK_CONFIG_RESET;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      case (dp_addr_reg)
        `RUN_CLOCK_GATE_1_OFF: begin
          run_clock_gate_1_reg <= wdata_gate;
        end
        `SLEEP_CLOCK_GATE_1_OFF: begin
          sleep_clock_gate_1_reg <= wdata_gate;
        end
        `DEEP_SLEEP_CLOCK_GATE_1_OFF: begin
          deep_sleep_clock_gate_1_reg <= wdata_gate;
        end
        `RUN_CLOCK_CONFIG_OFF: begin
          run_clock_config_reg <= hwdata;
        end
        `IRQ_MASK_OFF: begin
          irq_mask_reg <= hwdata[`IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Deep sleep dominates if both requests stand
  always_comb begin
    if (deep_sleep_sync) begin
      mode_next = MODE_DEEP_SLEEP;
    end else if (sleep_sync) begin
      mode_next = MODE_SLEEP;
    end else begin
      mode_next = MODE_RUN;
    end
  end

  always_comb begin
    gate_next = run_clock_gate_1_reg;
    if (run_clock_config_reg[`AUTO_CLOCK_GATING_SELECT_BIT]) begin
      case (mode_reg)
        MODE_SLEEP: gate_next = sleep_clock_gate_1_reg;
        MODE_DEEP_SLEEP: gate_next = deep_sleep_clock_gate_1_reg;
        default: gate_next = run_clock_gate_1_reg;
      endcase
    end
  end

  // Registered so the gate cells only ever see clean enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= MODE_RUN;
      gate_reg <= `GATE_RESET;
    end else begin
      mode_reg <= mode_next;
      gate_reg <= gate_next;
    end
  end

  assign timer_unit2_gate = gate_reg[`TIMER_UNIT2_BIT];
  assign timer_unit1_gate = gate_reg[`TIMER_UNIT1_BIT];
  assign timer_unit0_gate = gate_reg[`TIMER_UNIT0_BIT];
  assign two_wire_unit0_gate = gate_reg[`TWO_WIRE_UNIT0_BIT];
  assign sync_serial_unit0_gate = gate_reg[`SYNC_SERIAL_UNIT0_BIT];
  assign async_serial_unit1_gate = gate_reg[`ASYNC_SERIAL_UNIT1_BIT];
  assign async_serial_unit0_gate = gate_reg[`ASYNC_SERIAL_UNIT0_BIT];
  assign comparator_unit1_gate = gate_reg[`COMPARATOR_UNIT1_BIT];
  assign comparator_unit0_gate = gate_reg[`COMPARATOR_UNIT0_BIT];

  assign gate_bits = {comparator_unit1_gate, comparator_unit0_gate,
    timer_unit2_gate, timer_unit1_gate, timer_unit0_gate,
    two_wire_unit0_gate, sync_serial_unit0_gate,
    async_serial_unit1_gate, async_serial_unit0_gate};

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_cell
      clock_gate_cell u_cell (
        .clk_in(hclk),
        .enable(gate_bits[gi]),
        .clk_out(unit_clk[gi])
      );
    end
  endgenerate

  // Both comparators share one register window, so index 9 covers both; index 8 and 7 are units 1 and 0
  assign unit_enabled = {comparator_unit1_gate | comparator_unit0_gate,
    gate_bits};

  assign unit_fault = unit_access && |(unit_sel & ~unit_enabled);

  // Faults and mode changes both feed sticky status bits
  assign fault_evt = unit_fault;
  assign mode_evt = (mode_next != mode_reg);

  // Two-cycle ERROR response as AHB-Lite requires
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (dp_valid_reg && (dp_addr_reg == 12'hFFF)) begin
            bus_state_reg <= BUS_ERR1;
          end
        end
        // Back to idle at once, so a transfer pipelined behind is served
        BUS_ERR1: bus_state_reg <= BUS_IDLE;
        BUS_ERR2: bus_state_reg <= BUS_IDLE;
        default: bus_state_reg <= BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    hreadyout = 1'b1;
    hresp = 1'b0;
    if (dp_valid_reg && (dp_addr_reg == 12'hFFF) &&
        (bus_state_reg == BUS_IDLE)) begin
      hreadyout = 1'b0;
      hresp = 1'b1;
    end else if (bus_state_reg == BUS_ERR1) begin
      hresp = 1'b1;
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= '0;
    end else begin
      if (wr_en && dp_addr_reg == `IRQ_STATUS_OFF) begin
        irq_status_reg <= (irq_status_reg & ~hwdata[`IRQ_WIDTH-1:0])
          | {mode_evt, fault_evt};
      end else begin
        irq_status_reg <= irq_status_reg | {mode_evt, fault_evt};
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  always_comb begin
    case (dp_addr_reg)
      `RUN_CLOCK_GATE_1_OFF: hrdata = run_clock_gate_1_reg;
      `SLEEP_CLOCK_GATE_1_OFF: hrdata = sleep_clock_gate_1_reg;
      `DEEP_SLEEP_CLOCK_GATE_1_OFF: hrdata = deep_sleep_clock_gate_1_reg;
      `RUN_CLOCK_CONFIG_OFF: hrdata = run_clock_config_reg;
      `POWER_MODE_OFF: hrdata = {30'h0000_0000, mode_reg};
      `IRQ_STATUS_OFF: hrdata = {30'h0000_0000, irq_status_reg};
      `IRQ_MASK_OFF: hrdata = {30'h0000_0000, irq_mask_reg};
      default: hrdata = 32'h0000_0000;
    endcase
  end
endmodule // deep_sleep_peripheral_clock_gate
`default_nettype wire

// ---- verification/dsleep_gate_assertions.sv ----
// Purpose: bus reply and unit fault checks of the gating block
// Assumes: zero-wait OKAY, two-cycle ERROR replies
// Notes: bound to the top module below
`timescale 1ns/100ps
`default_nettype none
module dsleep_gate_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [9:0] unit_sel,
  input wire logic unit_access,
  input wire logic unit_fault,
  input wire logic comparator_unit1_gate,
  input wire logic timer_unit2_gate,
  input wire logic sync_serial_unit0_gate,
  input wire logic async_serial_unit0_gate
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && htrans[1] && hready;
  sequence rd_deep_s;
    take && !hwrite && haddr == 32'h400F_E124;
  endsequence
  sequence err_s;
    !hreadyout && hresp ##1 hreadyout && hresp;
  endsequence
  err_reply_a: assert property (!hreadyout |-> err_s)
    else $error("error reply not two cycles");
  unmapped_a: assert property (take && haddr == 32'h400F_E128 |=> err_s)
    else $error("unmapped access not refused");
  deep_ok_a: assert property (take && haddr == 32'h400F_E124 |=> hreadyout && !hresp)
    else $error("gating register access refused");
  rd_reserved_a: assert property (rd_deep_s |=> (hrdata & ~32'h0307_1013) == 0)
    else $error("reserved bits read nonzero");
  reset_off_a: assert property ($rose(hresetn) |-> !comparator_unit1_gate && !timer_unit2_gate)
    else $error("gate on after reset");
  fault_gated_a: assert property (unit_access && unit_sel[0] && !async_serial_unit0_gate |-> unit_fault)
    else $error("no fault on gated unit");
  no_fault_a: assert property (unit_access && unit_sel[2] && sync_serial_unit0_gate |-> !unit_fault)
    else $error("fault on clocked unit");
  idle_fault_a: assert property (!unit_access |-> !unit_fault)
    else $error("fault without access");
endmodule // dsleep_gate_assertions
bind deep_sleep_peripheral_clock_gate dsleep_gate_assertions chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .unit_sel, .unit_access, .unit_fault,
  .comparator_unit1_gate, .timer_unit2_gate, .sync_serial_unit0_gate,
  .async_serial_unit0_gate
);
`default_nettype wire

// ---- verification/deep_sleep_peripheral_clock_gate_bench.sv ----
// Purpose: register, mode and fault tests of the gating block
// Assumes: mode switches settle within 6 cycles
// Notes: bus replies taken at the rising edge that samples hready high
`timescale 1ns/100ps
`default_nettype none
`include "dsleep_gate_consts.svh"
`define CHECK(a, e) begin num_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module deep_sleep_peripheral_clock_gate_bench
  import dsleep_gate_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rs, irq;
  logic sleep_req, deep_sleep_req, unit_access, unit_fault;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [9:0] unit_sel;
  logic [8:0] unit_clk;
  logic c1, c0, t2, t1, t0, tw, ss, a1, a0;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int bits[9] = '{0, 1, 4, 12, 16, 17, 18, 24, 25};
  wire [8:0] gates = {c1, c0, t2, t1, t0, tw, ss, a1, a0};
  deep_sleep_peripheral_clock_gate DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_req,
    .deep_sleep_req, .unit_sel, .unit_access, .unit_fault,
    .comparator_unit1_gate(c1), .comparator_unit0_gate(c0),
    .timer_unit2_gate(t2), .timer_unit1_gate(t1), .timer_unit0_gate(t0),
    .two_wire_unit0_gate(tw), .sync_serial_unit0_gate(ss),
    .async_serial_unit1_gate(a1), .async_serial_unit0_gate(a0),
    .unit_clk, .irq
  );
  function automatic logic [8:0] pick(input logic [31:0] v);
    return {v[25], v[24], v[18:16], v[12], v[4], v[1:0]};
  endfunction
  task automatic bus_wait();
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rs = hresp;
    rd = hrdata;
  endtask
  task automatic xfer(input logic w, input logic [11:0] o,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= `SYSCTL_BASE + o;
    htrans <= 2'b10;
    hwrite <= w;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    bus_wait();
  endtask
  task automatic rchk(input logic [11:0] o, input logic [31:0] e);
    xfer(1'b0, o, 32'h0000_0000);
    `CHECK(rd, e)
  endtask
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask
  task automatic clk_is(input logic [8:0] e);
    @(posedge hclk);
    #2 `CHECK(unit_clk, e)
    @(negedge hclk);
    #1 `CHECK(unit_clk, 9'h000)
    @(posedge hclk);
  endtask
  task automatic irq_is(input logic e);
    @(negedge hclk);
    `CHECK(irq, e)
    @(posedge hclk);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, sleep_req, deep_sleep_req, unit_access} = '0;
    {haddr, hwdata, htrans, unit_sel} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`DEEP_SLEEP_CLOCK_GATE_1_OFF, 32'h0000_0000);
    xfer(1'b1, `DEEP_SLEEP_CLOCK_GATE_1_OFF, 32'hFFFF_FFFF);
    rchk(`DEEP_SLEEP_CLOCK_GATE_1_OFF, 32'h0307_1013);
    xfer(1'b0, `RUN_CLOCK_GATE_1_OFF, 32'h0000_0000);
    xfer(1'b1, `RUN_CLOCK_GATE_1_OFF, rd | 32'h0000_1010);
    xfer(1'b1, `SLEEP_CLOCK_GATE_1_OFF, 32'h0102_0001);
    deep_sleep_req <= 1'b1;
    settle();
    `CHECK(gates, pick(32'h0000_1010))
    xfer(1'b1, `RUN_CLOCK_CONFIG_OFF, 32'h0800_0000);
    settle();
    `CHECK(gates, pick(32'h0307_1013))
    rchk(`POWER_MODE_OFF, 32'h0000_0002);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b1, `DEEP_SLEEP_CLOCK_GATE_1_OFF, 32'h0000_0001 << bits[i]);
      settle();
      `CHECK(gates, 9'h001 << i)
      clk_is(9'h001 << i);
    end
    deep_sleep_req <= 1'b0;
    sleep_req <= 1'b1;
    settle();
    `CHECK(gates, pick(32'h0102_0001))
    sleep_req <= 1'b0;
    settle();
    `CHECK(gates, pick(32'h0000_1010))
    xfer(1'b1, `IRQ_STATUS_OFF, 32'h0000_0003);
    xfer(1'b1, `IRQ_MASK_OFF, 32'h0000_0001);
    irq_is(1'b0);
    // Unit 0 gated off, unit 2 clocked
    unit_sel <= 10'h001;
    unit_access <= 1'b1;
    @(negedge hclk);
    `CHECK(unit_fault, 1'b1)
    @(posedge hclk);
    unit_sel <= 10'h004;
    @(negedge hclk);
    `CHECK(unit_fault, 1'b0)
    @(posedge hclk);
    unit_access <= 1'b0;
    @(posedge hclk);
    irq_is(1'b1);
    xfer(1'b1, `IRQ_MASK_OFF, 32'h0000_0000);
    irq_is(1'b0);
    xfer(1'b1, `IRQ_MASK_OFF, 32'h0000_0001);
    irq_is(1'b1);
    xfer(1'b1, `IRQ_STATUS_OFF, 32'h0000_0001);
    irq_is(1'b0);
    xfer(1'b0, 12'h128, 32'h0000_0000);
    `CHECK(rs, 1'b1)
    complete_run();
  end
endmodule // deep_sleep_peripheral_clock_gate_bench
`default_nettype wire
